// >>> rtl/sram_boundary_scan_tap.sv
// test access port with instruction, bypass, id and boundary registers
`timescale 1ns/1ps
// Operation
// - sixteen-state controller steps on tms each edge
// - tms and tdi sampled on rising tck
// - tdo on falling edge, driven only shifting
// - floating tms and tdi read as one
// - five tms-high edges reach reset state
// - power-up reset leaves tdo high impedance
// - one register between tdi msb, tdo lsb
// - three-bit instruction register shifted in Shift-IR
// - instruction resets to idcode
// - Capture-IR loads 01 into low bits
// - new instruction acts only at Update-IR
// - one-bit bypass register, cleared when executing
// - boundary register 73 or 54 bits
// - boundary register captures ring, shifts it out
// - fixed 32-bit id loaded under idcode
// - scan data never drives memory pins
// - all-zero code is extest, outputs high-z
// - sample-highz selects boundary, outputs high-z
// - Update-DR under sample changes nothing
// - bypass routes tdi to tdo, one stage
module sram_boundary_scan_tap
    import sram_tap_pkg::*;
#(
    parameter bit WIDE_X36 = 1'b1,
    localparam int BSR_LEN = WIDE_X36 ? BSR_LEN_X36 : BSR_LEN_X18
) (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               tck,
    input  wire logic               tms,
    input  wire logic               tdi,
    input  wire logic [BSR_LEN-1:0] ring_pins,
    output logic                    tdo,
    output logic                    tdo_oe,
    output logic                    mem_out_highz
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic               tap_rst;
    logic [BSR_LEN-1:0] ring_hold;
    tap_state_type      state_q;
    tap_state_type      state_d;
    logic [IR_LEN-1:0]  ir_q;
    logic [IR_LEN-1:0]  ir_d;
    logic [IR_LEN-1:0]  ir_shift_q;
    logic [IR_LEN-1:0]  ir_shift_d;
    logic               bypass_q;
    logic               bypass_d;
    logic [IDR_LEN-1:0] idr_q;
    logic [IDR_LEN-1:0] idr_d;
    logic [BSR_LEN-1:0] bsr_q;
    logic [BSR_LEN-1:0] bsr_d;
    logic               tms_v;
    logic               tdi_v;
    logic               shifting;
    logic               tdo_bit;
    logic               tdo_q;
    logic               tdo_d;
    logic               tdo_oe_q;
    logic               tdo_oe_d;
    logic               highz_s;
    logic               highz_q;
    logic               highz_d;

    ////////////////////////////////////////////////////////////////////////
    // crossings between system clock and test clock

    // power-up reset carried into the test clock domain
    level_sync u_rst_sync (
        .clk (tck),
        .rst (1'b0),
        .d   (rst),
        .q   (tap_rst)
    );

    // pin ring snapshot, words handed over by toggle handshake
    snapshot_xfer #(
        .W (BSR_LEN)
    ) u_ring_xfer (
        .src_clk  (sys_clk),
        .src_rst  (rst),
        .src_data (ring_pins),
        .dst_clk  (tck),
        .dst_rst  (tap_rst),
        .dst_data (ring_hold)
    );

    // high-z request from the active instruction into system domain
    level_sync u_highz_sync (
        .clk (sys_clk),
        .rst (rst),
        .d   (outputs_highz(ir_q)),
        .q   (highz_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // controller state

    // inputs taken as seen at the rising edge; pads pull them high
    always_comb begin
        tms_v = tms;
        tdi_v = tdi;
    end

    // standard sixteen-state walk on tms
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RESET:      state_d = tms_v ? ST_RESET    : ST_IDLE;
            ST_IDLE:       state_d = tms_v ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:     state_d = tms_v ? ST_SEL_IR   : ST_CAPTURE_DR;
            ST_CAPTURE_DR: state_d = tms_v ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR:   state_d = tms_v ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR:   state_d = tms_v ? ST_UPDATE_DR : ST_PAUSE_DR;
            ST_PAUSE_DR:   state_d = tms_v ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR:   state_d = tms_v ? ST_UPDATE_DR : ST_SHIFT_DR;
            ST_UPDATE_DR:  state_d = tms_v ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:     state_d = tms_v ? ST_RESET    : ST_CAPTURE_IR;
            ST_CAPTURE_IR: state_d = tms_v ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR:   state_d = tms_v ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR:   state_d = tms_v ? ST_UPDATE_IR : ST_PAUSE_IR;
            ST_PAUSE_IR:   state_d = tms_v ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR:   state_d = tms_v ? ST_UPDATE_IR : ST_SHIFT_IR;
            ST_UPDATE_IR:  state_d = tms_v ? ST_SEL_DR   : ST_IDLE;
            default:       state_d = ST_RESET;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // instruction register

    always_comb begin
        ir_d       = ir_q;
        ir_shift_d = ir_shift_q;
        if (state_q == ST_CAPTURE_IR) begin
            ir_shift_d = {IR_CAPTURE_MSB, IR_CAPTURE_PAT};
        end
        if (state_q == ST_SHIFT_IR) begin
            ir_shift_d = {tdi_v, ir_shift_q[IR_LEN-1:1]};
        end
        if (state_q == ST_UPDATE_IR) begin
            ir_d = ir_shift_q;
        end
        // idcode already in force on the edge that enters reset
        if (state_d == ST_RESET) begin
            ir_d = INS_IDCODE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data registers: capture, shift; update does nothing

    // reserved and bypass codes fall to the bypass bit
    always_comb begin
        bypass_d = bypass_q;
        idr_d    = idr_q;
        bsr_d    = bsr_q;
        if (state_q == ST_CAPTURE_DR) begin
            if (sel_bsr(ir_q)) begin
                bsr_d = ring_hold;
            end else if (sel_idr(ir_q)) begin
                idr_d = IDCODE_VALUE;
            end else begin
                bypass_d = BYPASS_CAPTURE;
            end
        end
        if (state_q == ST_SHIFT_DR) begin
            if (sel_bsr(ir_q)) begin
                bsr_d = {tdi_v, bsr_q[BSR_LEN-1:1]};
            end else if (sel_idr(ir_q)) begin
                idr_d = {tdi_v, idr_q[IDR_LEN-1:1]};
            end else begin
                bypass_d = tdi_v;
            end
        end
        // update-dr drives no pin: nothing here for it
    end

    // rising-edge registers of the controller
    always_ff @(posedge tck) begin
        if (tap_rst) begin
            state_q    <= ST_RESET;
            ir_q       <= INS_IDCODE;
            ir_shift_q <= '0;
            bypass_q   <= 1'b0;
            idr_q      <= '0;
            bsr_q      <= '0;
        end else begin
            state_q    <= state_d;
            ir_q       <= ir_d;
            ir_shift_q <= ir_shift_d;
            bypass_q   <= bypass_d;
            idr_q      <= idr_d;
            bsr_q      <= bsr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // tdo on the falling edge

    // lsb of the one selected register
    always_comb begin
        shifting = (state_q == ST_SHIFT_IR) || (state_q == ST_SHIFT_DR);
        if (state_q == ST_SHIFT_IR) begin
            tdo_bit = ir_shift_q[0];
        end else if (sel_bsr(ir_q)) begin
            tdo_bit = bsr_q[0];
        end else if (sel_idr(ir_q)) begin
            tdo_bit = idr_q[0];
        end else begin
            tdo_bit = bypass_q;
        end
        tdo_d    = tdo_bit;
        tdo_oe_d = shifting;
    end

    always_ff @(negedge tck) begin
        if (tap_rst) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q    <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory output high-z request in the system domain

    always_comb begin
        highz_d = highz_s;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            highz_q <= 1'b0;
        end else begin
            highz_q <= highz_d;
        end
    end

    assign tdo           = tdo_q;
    assign tdo_oe        = tdo_oe_q;
    assign mem_out_highz = highz_q;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    property p_tms_reset;
        @(posedge tck) disable iff (tap_rst)
        tms[*5] |=> (state_q == ST_RESET);
    endproperty
    a_tms_reset: assert property (p_tms_reset)
        else $error("five tms highs did not reach reset");

    property p_ir_reset;
        @(posedge tck) disable iff (tap_rst)
        (state_q == ST_RESET) |-> (ir_q == INS_IDCODE);
    endproperty
    a_ir_reset: assert property (p_ir_reset)
        else $error("instruction not idcode after reset state");

    property p_capture_ir;
        @(posedge tck) disable iff (tap_rst)
        (state_q == ST_CAPTURE_IR) |=> (ir_shift_q[1:0] == IR_CAPTURE_PAT);
    endproperty
    a_capture_ir: assert property (p_capture_ir)
        else $error("capture-ir pattern wrong");

    property p_ir_hold;
        @(posedge tck) disable iff (tap_rst)
        (state_q != ST_UPDATE_IR) && (state_d != ST_RESET)
        |=> $stable(ir_q);
    endproperty
    a_ir_hold: assert property (p_ir_hold)
        else $error("instruction changed outside update-ir");

    property p_bypass_zero;
        @(posedge tck) disable iff (tap_rst)
        (state_q == ST_CAPTURE_DR) && !sel_bsr(ir_q) && !sel_idr(ir_q)
        |=> (bypass_q == 1'b0);
    endproperty
    a_bypass_zero: assert property (p_bypass_zero)
        else $error("bypass bit not cleared on capture");

    property p_bypass_path;
        @(posedge tck) disable iff (tap_rst)
        (state_q == ST_SHIFT_DR) && (ir_q == INS_BYPASS)
        |=> (bypass_q == $past(tdi));
    endproperty
    a_bypass_path: assert property (p_bypass_path)
        else $error("bypass stage did not take tdi");

    property p_idcode_load;
        @(posedge tck) disable iff (tap_rst)
        (state_q == ST_CAPTURE_DR) && (ir_q == INS_IDCODE)
        |=> (idr_q == IDCODE_VALUE);
    endproperty
    a_idcode_load: assert property (p_idcode_load)
        else $error("id register not loaded");

    property p_bsr_capture;
        @(posedge tck) disable iff (tap_rst)
        (state_q == ST_CAPTURE_DR) && sel_bsr(ir_q)
        |=> (bsr_q == $past(ring_hold));
    endproperty
    a_bsr_capture: assert property (p_bsr_capture)
        else $error("boundary register missed the ring");

    property p_update_dr_quiet;
        @(posedge tck) disable iff (tap_rst)
        (state_q == ST_UPDATE_DR) |=> $stable(bsr_q) && $stable(ir_q);
    endproperty
    a_update_dr_quiet: assert property (p_update_dr_quiet)
        else $error("update-dr disturbed a register");

    property p_tdo_oe;
        @(negedge tck) disable iff (tap_rst)
        ##1 (tdo_oe_q == $past(shifting));
    endproperty
    a_tdo_oe: assert property (p_tdo_oe)
        else $error("tdo enable outside shift states");

    c_bsr_shift: cover property (@(posedge tck) disable iff (tap_rst)
        (state_q == ST_SHIFT_DR) && sel_bsr(ir_q));
    c_update_ir: cover property (@(posedge tck) disable iff (tap_rst)
        (state_q == ST_UPDATE_IR) ##1 (ir_q == INS_SAMPLE_Z));
    c_tms_reset: cover property (@(posedge tck) disable iff (tap_rst)
        (state_q == ST_SHIFT_DR) ##1 tms[*5]);

endmodule : sram_boundary_scan_tap

// >>> rtl/sram_tap_pkg.sv
// constants, state type and decode functions for the memory test port
package sram_tap_pkg;

    localparam int IR_LEN      = 3;
    localparam int IDR_LEN     = 32;
    localparam int BSR_LEN_X36 = 73;
    localparam int BSR_LEN_X18 = 54;

    // instruction codes
    localparam logic [2:0] INS_EXTEST   = 3'h0;
    localparam logic [2:0] INS_IDCODE   = 3'h1;
    localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [2:0] INS_SAMPLE   = 3'h4;
    localparam logic [2:0] INS_BYPASS   = 3'h7;

    // capture pattern of the two low instruction bits
    localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
    localparam logic       IR_CAPTURE_MSB = 1'h0;
    // identification value; arbitrary, lsb kept at one
    localparam logic [31:0] IDCODE_VALUE  = 32'h0A5A_5001;
    localparam logic        BYPASS_CAPTURE = 1'h0;

    typedef enum logic [15:0] {
        ST_RESET      = 16'h0001,
        ST_IDLE       = 16'h0002,
        ST_SEL_DR     = 16'h0004,
        ST_CAPTURE_DR = 16'h0008,
        ST_SHIFT_DR   = 16'h0010,
        ST_EXIT1_DR   = 16'h0020,
        ST_PAUSE_DR   = 16'h0040,
        ST_EXIT2_DR   = 16'h0080,
        ST_UPDATE_DR  = 16'h0100,
        ST_SEL_IR     = 16'h0200,
        ST_CAPTURE_IR = 16'h0400,
        ST_SHIFT_IR   = 16'h0800,
        ST_EXIT1_IR   = 16'h1000,
        ST_PAUSE_IR   = 16'h2000,
        ST_EXIT2_IR   = 16'h4000,
        ST_UPDATE_IR  = 16'h8000
    } tap_state_type;

    // boundary register selected (extest, sample-highz, sample)
    function automatic logic sel_bsr(input logic [2:0] ins);
        sel_bsr = (ins == INS_EXTEST) || (ins == INS_SAMPLE_Z) ||
                  (ins == INS_SAMPLE);
    endfunction : sel_bsr

    // identification register selected
    function automatic logic sel_idr(input logic [2:0] ins);
        sel_idr = (ins == INS_IDCODE);
    endfunction : sel_idr

    // memory outputs forced to high impedance
    function automatic logic outputs_highz(input logic [2:0] ins);
        outputs_highz = (ins == INS_EXTEST) || (ins == INS_SAMPLE_Z);
    endfunction : outputs_highz

endpackage : sram_tap_pkg

// >>> rtl/level_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module level_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    // first stage only feeds the second
    always_comb begin
        meta_d = d;
        sync_d = meta_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q = sync_q;
endmodule : level_sync

// >>> rtl/snapshot_xfer.sv
// toggle handshake moving a pin-ring snapshot into the test clock domain
`timescale 1ns/1ps
module snapshot_xfer #(
    parameter int W = 73
) (
    input  wire logic         src_clk,
    input  wire logic         src_rst,
    input  wire logic [W-1:0] src_data,
    input  wire logic         dst_clk,
    input  wire logic         dst_rst,
    output logic [W-1:0]      dst_data
);
    logic [W-1:0] hold_q;
    logic [W-1:0] hold_d;
    logic         req_q;
    logic         req_d;
    logic         ack_s;
    logic [W-1:0] dst_q;
    logic [W-1:0] dst_d;
    logic         ack_q;
    logic         ack_d;
    logic         req_s;

    // source: reload only when the last word was taken
    always_comb begin
        hold_d = hold_q;
        req_d  = req_q;
        if (req_q == ack_s) begin
            hold_d = src_data;
            req_d  = ~req_q;
        end
    end

    always_ff @(posedge src_clk) begin
        if (src_rst) begin
            hold_q <= '0;
            req_q  <= 1'b0;
        end else begin
            hold_q <= hold_d;
            req_q  <= req_d;
        end
    end

    level_sync u_req_sync (
        .clk (dst_clk),
        .rst (dst_rst),
        .d   (req_q),
        .q   (req_s)
    );

    // destination: hold is stable while request and ack differ
    always_comb begin
        dst_d = dst_q;
        ack_d = ack_q;
        if (req_s != ack_q) begin
            dst_d = hold_q;
            ack_d = ~ack_q;
        end
    end

    always_ff @(posedge dst_clk) begin
        if (dst_rst) begin
            dst_q <= '0;
            ack_q <= 1'b0;
        end else begin
            dst_q <= dst_d;
            ack_q <= ack_d;
        end
    end

    level_sync u_ack_sync (
        .clk (src_clk),
        .rst (src_rst),
        .d   (ack_q),
        .q   (ack_s)
    );

    assign dst_data = dst_q;
endmodule : snapshot_xfer

// >>> testbench/jtag_ctrl_model.sv
// far-side test controller model: clock, mode and data lines
`timescale 1ns/1ps
module jtag_ctrl_model (
    output logic tck,
    output wire  tms,
    output wire  tdi
);
    logic tms_d;
    logic tdi_d;
    logic drv_en;

    ////////////////////////////////////////////////////////////////////////
    // released lines float to the pull-up level
    assign tms = drv_en ? tms_d : 1'b1;
    assign tdi = drv_en ? tdi_d : 1'b1;

    // clock parked low between frames
    initial begin
        tck    = 1'b0;
        tms_d  = 1'b1;
        tdi_d  = 1'b1;
        drv_en = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one 125 ns period; lines change right after the fall
    task automatic tick(input logic en, input logic m, input logic d);
        drv_en = en;
        tms_d  = m;
        tdi_d  = d;
        #62.5 tck = 1'b1;
        #62.5 tck = 1'b0;
    endtask : tick

    // five mode-high edges with the lines released
    task automatic tap_reset();
        repeat (5) tick(1'b0, 1'b1, 1'b1);
    endtask : tap_reset
endmodule : jtag_ctrl_model

// >>> testbench/test_sram_boundary_scan_tap.sv
// self-checking bench for the memory test port
`timescale 1ns/1ps
module test_sram_boundary_scan_tap;
    import sram_tap_pkg::*;
    localparam int BL = BSR_LEN_X36;
    logic          sys_clk;
    logic          rst;
    logic [BL-1:0] ring_pins;
    logic [BL-1:0] ring_v;
    wire           tck;
    wire           tms;
    wire           tdi;
    logic          tdo;
    logic          tdo_oe;
    logic          mem_out_highz;
    logic          exp_q[$];
    int            errors;
    int            tests_run;
    logic [2:0]    code;
    logic [127:0]  cap;
    logic          hz;
    int            len;

    jtag_ctrl_model link (.tck(tck), .tms(tms), .tdi(tdi));

    sram_boundary_scan_tap #(.WIDE_X36(1'b1)) uut (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .tck           (tck),
        .tms           (tms),
        .tdi           (tdi),
        .ring_pins     (ring_pins),
        .tdo           (tdo),
        .tdo_oe        (tdo_oe),
        .mem_out_highz (mem_out_highz)
    );

    ////////////////////////////////////////////////////////////////////////
    // 50 MHz system clock
    always #10 sys_clk = ~sys_clk;

    // verdict and end of run
    task automatic stop_test();
        $display("counts: tests_run=%0d errors=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    // compare of one bit
    task automatic cmp_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : cmp_bit

    // compare of the output high-z level once settled
    task automatic cmp_hz(input logic exp);
        repeat (8) @(posedge sys_clk);
        #1;
        cmp_bit(mem_out_highz, exp);
    endtask : cmp_hz

    // several clock periods, mode bits taken lsb first
    task automatic walk(input logic [7:0] ms, input int n);
        for (int i = 0; i < n; i++) begin
            link.tick(1'b1, ms[i], 1'b1);
        end
    endtask : walk

    ////////////////////////////////////////////////////////////////////////
    // driven tdo bits taken against the oldest note
    always @(posedge tck) begin
        if (rst === 1'b0 && tdo_oe === 1'b1 && exp_q.size() > 0) begin
            cmp_bit(tdo, exp_q.pop_front());
        end else if (rst === 1'b0 && tdo_oe !== 1'b0) begin
            cmp_bit(tdo_oe, 1'b0);
        end
    end

    // instruction load, pausing before the update
    task automatic ir_scan(input logic [2:0] c, input logic prev_hz);
        exp_q.push_back(IR_CAPTURE_PAT[0]);
        exp_q.push_back(IR_CAPTURE_PAT[1]);
        exp_q.push_back(IR_CAPTURE_MSB);
        walk(8'h03, 4);
        for (int i = 0; i < 3; i++) begin
            link.tick(1'b1, i == 2, c[i]);
        end
        walk(8'h00, 1);
        cmp_hz(prev_hz);
        walk(8'h03, 3);
    endtask : ir_scan

    // data scan of n captured bits plus four fed-through bits
    task automatic dr_scan(input int n, input logic [127:0] c);
        logic [3:0] t;
        t = 4'($urandom);
        for (int k = 0; k < n; k++) begin
            exp_q.push_back(c[k]);
        end
        for (int k = 0; k < 4; k++) begin
            exp_q.push_back(t[k]);
        end
        walk(8'h01, 3);
        for (int k = 0; k < n + 4; k++) begin
            link.tick(1'b1, k == n + 3, (k < 4) ? t[k] : 1'($urandom));
        end
        walk(8'h01, 2);
    endtask : dr_scan

    ////////////////////////////////////////////////////////////////////////
    // watchdog against a hang
    initial begin
        #400000;
        errors++;
        stop_test();
    end

    // main sequence
    initial begin
        sys_clk   = 1'b0;
        rst       = 1'b1;
        ring_pins = '0;
        errors    = 0;
        tests_run = 0;
        void'($urandom(32'h39F1));
        fork
            begin
                repeat (20) @(posedge sys_clk);
                rst <= 1'b0;
            end
            repeat (8) link.tick(1'b0, 1'b1, 1'b1);
        join
        link.tap_reset();
        cmp_bit(tdo_oe, 1'b0);
        cmp_hz(1'b0);
        walk(8'h00, 1);
        dr_scan(IDR_LEN, 128'(IDCODE_VALUE));
        $display("test 1 done: id after reset");
        hz = 1'b0;
        // every defined code; reserved ones are never loaded
        for (int c = 0; c < 8; c++) begin
            if (c == 3 || c == 5 || c == 6) continue;
            code   = 3'(c);
            ring_v = BL'({$urandom, $urandom, $urandom});
            @(posedge sys_clk);
            ring_pins <= ring_v;
            ir_scan(code, hz);
            hz = (code == INS_EXTEST) || (code == INS_SAMPLE_Z);
            cmp_hz(hz);
            case (code)
                INS_EXTEST, INS_SAMPLE_Z, INS_SAMPLE: begin
                    len = BL;
                    cap = 128'(ring_v);
                end
                INS_IDCODE: begin
                    len = IDR_LEN;
                    cap = 128'(IDCODE_VALUE);
                end
                default: begin
                    len = 1;
                    cap = '0;
                end
            endcase
            dr_scan(len, cap);
            cmp_hz(hz);
        end
        $display("test 2 done: all codes");
        ir_scan(INS_EXTEST, hz);
        cmp_hz(1'b1);
        exp_q.push_back(ring_v[0]);
        walk(8'h01, 3);
        link.tap_reset();
        cmp_hz(1'b0);
        walk(8'h00, 1);
        dr_scan(IDR_LEN, 128'(IDCODE_VALUE));
        cmp_bit(exp_q.size() == 0, 1'b1);
        $display("test 3 done: reset in mid-scan");
        stop_test();
    end
endmodule : test_sram_boundary_scan_tap
